//--- dwc_defs.svh
// Constants of the write checksum alert and bus inversion block.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef DWC_DEFS_SVH
`define DWC_DEFS_SVH
`define DWC_MR5_CRC_STATUS_BIT 3
`define DWC_MR5_MASK_EN_BIT    10
`define DWC_MR5_WR_INV_BIT     11
`define DWC_MR5_RD_INV_BIT     12
`define DWC_MR1_TERM_STB_BIT   11
`define DWC_LOG3_CRC_FLAG_BIT  7
`define DWC_BURST_BEATS        4'h8
`define DWC_ZERO_LIMIT         4'h4
`define DWC_CRC_INIT           8'hff
`define DWC_CRC_POLY           8'h07
`define DWC_CRC_LATENCY_CLKS   3
`define DWC_CRC_PULSE_CLKS     10
`define DWC_PARITY_PULSE_CLKS  48
`define DWC_PARITY_MIN_CLKS    45
`define DWC_FIFO_DEPTH         32
`endif

//--- dwc_pkg.sv
// Types shared by the write checksum alert and bus inversion block.
// Assumes nothing of its surroundings.
package dwc_pkg;
   typedef enum logic [1:0] {
      DWC_X4  = 2'b00,
      DWC_X8  = 2'b01,
      DWC_X16 = 2'b10
   } dwc_width_t;

   typedef enum logic [1:0] {
      DWC_IDLE    = 2'b00,
      DWC_WAIT    = 2'b01,
      DWC_CRC_LOW = 2'b10,
      DWC_PAR_LOW = 2'b11
   } dwc_alert_t;

   typedef struct packed {
      logic [15:0] dq;
      logic [1:0]  flag_n;
   } dwc_beat_t;

   typedef struct packed {
      logic [1:0]  mask;
      logic [15:0] data;
   } dwc_store_t;
endpackage : dwc_pkg

//--- dwc_fifo.sv
// Synchronous FIFO between the write decoder and the array store port.
// Assumes one clock domain and a power of two depth.
`timescale 1ns/1ps
module dwc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    wr_ptr_next;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;
   logic             out_valid_next;
   logic             in_ready_next;

   always_comb
   begin
      push           = in_valid_in && in_ready_out;
      pop            = (count_reg != '0) && (!out_valid_out || out_ready_in);
      wr_ptr_next    = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next    = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_next     = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      out_valid_next = pop || (out_valid_out && !out_ready_in);
      in_ready_next  = (count_next + {{AW{1'b0}}, out_valid_next}) < (AW+1)'(DEPTH);
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         out_valid_out <= 1'b0;
         in_ready_out  <= 1'b1;
      end
      else
      begin
         wr_ptr_reg    <= wr_ptr_next;
         rd_ptr_reg    <= rd_ptr_next;
         count_reg     <= count_next;
         out_valid_out <= out_valid_next;
         in_ready_out  <= in_ready_next;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data_in;
      if (pop)
         out_data_out <= mem[rd_ptr_reg];
   end
endmodule : dwc_fifo

//--- dwc_top.sv
// Write checksum alert and data bus inversion logic of the data lanes.
// Assumes pins arrive asynchronously and controls come from logic on mclk_in.
`timescale 1ns/1ps
`include "dwc_defs.svh"

// Overview of operation
// - Checksum errors share the parity error line.
// - Checksum error pulse short; parity pulse long.
// - Checksum error sets mode register five bit.
// - Status bit mirrored into error log flag.
// - Status stays set until mode write clears it.
// - Compare checksum, drive alert CRC_LATENCY + 1 clocks after mismatch flag if alert idle and no parity error.
// - Pulse width spans drive low to release.
// - Inversion only in x8 and x16 widths.
// - No inversion on multipurpose register reads.
// - Read inversion independent of write and mask.
// - Write lane flag low inverts stored byte.
// - Write lane flag high stores byte unchanged.
// - Read byte over four zeros inverted, flag low.
// - Eight beats, one byte and flag per lane.
module dwc_top #(
   parameter int CRC_LATENCY = `DWC_CRC_LATENCY_CLKS,
   parameter int CRC_PULSE   = `DWC_CRC_PULSE_CLKS,
   parameter int PAR_PULSE   = `DWC_PARITY_PULSE_CLKS,
   parameter int FIFO_DEPTH  = `DWC_FIFO_DEPTH
) (
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   input  dwc_pkg::dwc_width_t     data_width_in,
   input  wire logic [15:0]        mode_register_five_in,
   input  wire logic [15:0]        mode_register_one_in,
   input  wire logic               mode_register_set_command_in,
   input  wire logic               write_crc_enable_in,
   input  wire logic               multipurpose_register_read_in,
   input  wire logic               command_address_parity_err_in,
   input  wire logic               link_strobe_in,
   input  wire logic               write_frame_in,
   input  wire logic [15:0]        dq_in,
   output logic [15:0]             dq_out,
   output logic                    dq_oe_out,
   input  wire logic               lower_lane_invert_flag_n_in,
   output logic                    lower_lane_invert_flag_n_out,
   output logic                    lower_lane_invert_flag_oe_out,
   input  wire logic               upper_lane_invert_flag_n_in,
   output logic                    upper_lane_invert_flag_n_out,
   output logic                    upper_lane_invert_flag_oe_out,
   output logic                    alert_n_out,
   output logic                    alert_oe_out,
   input  wire logic               read_valid_in,
   input  wire logic [15:0]        read_data_in,
   output logic                    beat_ready_out,
   output logic                    store_valid_out,
   input  wire logic               store_ready_in,
   output dwc_pkg::dwc_store_t     store_word_out,
   output logic                    crc_error_status_out,
   output logic [7:0]              error_log_register_three_out
);
   localparam int LAT_P1 = CRC_LATENCY + 1;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [8:0] bits);
      logic [7:0] c;
      c = crc;
      for (int i = 8; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ bits[i]) ? `DWC_CRC_POLY : 8'h00);
      return c;
   endfunction : crc_step

   function automatic logic [3:0] zero_count(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
         n = n + {3'h0, ~b[i]};
      return n;
   endfunction : zero_count

   // ----------------------------------------
   // Pin synchronisers and strobe edge
   // ----------------------------------------
   dwc_pkg::dwc_beat_t pin_s1_reg;
   dwc_pkg::dwc_beat_t pin_s2_reg;
   logic [1:0]         stb_s_reg;
   logic               stb_s3_reg;
   logic [1:0]         frm_s_reg;
   logic               stb_rise;

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         stb_s_reg  <= 2'h0;
         stb_s3_reg <= 1'b0;
         frm_s_reg  <= 2'h0;
      end
      else
      begin
         pin_s1_reg <= {dq_in, upper_lane_invert_flag_n_in, lower_lane_invert_flag_n_in};
         pin_s2_reg <= pin_s1_reg;
         stb_s_reg  <= {stb_s_reg[0], link_strobe_in};
         stb_s3_reg <= stb_s_reg[1];
         frm_s_reg  <= {frm_s_reg[0], write_frame_in};
      end
   end

   assign stb_rise = stb_s_reg[1] && !stb_s3_reg;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   logic wide_ok;
   logic term_stb;
   logic wr_inv_en;
   logic mask_en;
   logic rd_inv_en;

   always_comb
   begin
      wide_ok   = (data_width_in == dwc_pkg::DWC_X8) || (data_width_in == dwc_pkg::DWC_X16);
      term_stb  = mode_register_one_in[`DWC_MR1_TERM_STB_BIT];
      wr_inv_en = wide_ok && !term_stb && mode_register_five_in[`DWC_MR5_WR_INV_BIT];
      mask_en   = wide_ok && !term_stb && mode_register_five_in[`DWC_MR5_MASK_EN_BIT];
      rd_inv_en = wide_ok && !term_stb && mode_register_five_in[`DWC_MR5_RD_INV_BIT];
   end

   // ----------------------------------------
   // Write burst decode and checksum
   // ----------------------------------------
   logic [3:0]          beat_reg;
   logic [3:0]          beat_next;
   logic [7:0]          crc_lo_reg;
   logic [7:0]          crc_lo_next;
   logic [7:0]          crc_hi_reg;
   logic [7:0]          crc_hi_next;
   logic                mismatch_reg;
   logic                mismatch_next;
   logic                push_reg;
   logic                push_next;
   dwc_pkg::dwc_store_t push_word_reg;
   dwc_pkg::dwc_store_t push_word_next;
   logic                fifo_ready;

   always_comb
   begin
      beat_next      = beat_reg;
      crc_lo_next    = crc_lo_reg;
      crc_hi_next    = crc_hi_reg;
      mismatch_next  = 1'b0;
      push_next      = 1'b0;
      push_word_next = push_word_reg;
      if (!frm_s_reg[1])
      begin
         beat_next   = 4'h0;
         crc_lo_next = `DWC_CRC_INIT;
         crc_hi_next = `DWC_CRC_INIT;
      end
      else if (stb_rise && beat_reg < `DWC_BURST_BEATS)
      begin
         beat_next = beat_reg + 4'h1;
         crc_lo_next = crc_step(crc_lo_reg, {pin_s2_reg.dq[7:0], pin_s2_reg.flag_n[0]});
         crc_hi_next = crc_step(crc_hi_reg, {pin_s2_reg.dq[15:8], pin_s2_reg.flag_n[1]});
         push_next = 1'b1;
         for (int l = 0; l < 2; l++)
         begin
            push_word_next.data[l*8 +: 8] = (wr_inv_en && !pin_s2_reg.flag_n[l]) ?
                                            ~pin_s2_reg.dq[l*8 +: 8] :
                                            pin_s2_reg.dq[l*8 +: 8];
            push_word_next.mask[l] = mask_en && !pin_s2_reg.flag_n[l];
         end
      end
      else if (stb_rise && beat_reg == `DWC_BURST_BEATS && write_crc_enable_in)
      begin
         beat_next     = beat_reg + 4'h1;
         mismatch_next = (crc_lo_reg != pin_s2_reg.dq[7:0]) ||
                         (data_width_in == dwc_pkg::DWC_X16 && crc_hi_reg != pin_s2_reg.dq[15:8]);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         beat_reg      <= 4'h0;
         crc_lo_reg    <= `DWC_CRC_INIT;
         crc_hi_reg    <= `DWC_CRC_INIT;
         mismatch_reg  <= 1'b0;
         push_reg      <= 1'b0;
         push_word_reg <= '0;
      end
      else
      begin
         beat_reg      <= beat_next;
         crc_lo_reg    <= crc_lo_next;
         crc_hi_reg    <= crc_hi_next;
         mismatch_reg  <= mismatch_next;
         push_reg      <= push_next;
         push_word_reg <= push_word_next;
      end
   end

   dwc_fifo #(
      .WIDTH ($bits(dwc_pkg::dwc_store_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_in       (mclk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push_reg),
      .in_ready_out  (fifo_ready),
      .in_data_in    (push_word_reg),
      .out_valid_out (store_valid_out),
      .out_ready_in  (store_ready_in),
      .out_data_out  (store_word_out)
   );

   assign beat_ready_out = fifo_ready;

   // ----------------------------------------
   // Error status and alert line
   // ----------------------------------------
   dwc_pkg::dwc_alert_t state_reg;
   dwc_pkg::dwc_alert_t state_next;
   logic [7:0]          cnt_reg;
   logic [7:0]          cnt_next;
   logic                status_reg;
   logic                status_next;
   logic                oe_next;

   always_comb
   begin
      status_next = mismatch_reg || (status_reg && !(mode_register_set_command_in &&
                    !mode_register_five_in[`DWC_MR5_CRC_STATUS_BIT]));
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      case (state_reg)
         dwc_pkg::DWC_IDLE:
         begin
            if (command_address_parity_err_in)
            begin
               state_next = dwc_pkg::DWC_PAR_LOW;
               cnt_next   = 8'(PAR_PULSE - 1);
            end
            else if (mismatch_reg)
            begin
               state_next = dwc_pkg::DWC_WAIT;
               cnt_next   = 8'(CRC_LATENCY - 1);
            end
         end
         dwc_pkg::DWC_WAIT:
         begin
            if (cnt_reg == 8'h00)
            begin
               state_next = dwc_pkg::DWC_CRC_LOW;
               cnt_next   = 8'(CRC_PULSE - 1);
            end
            else
               cnt_next = cnt_reg - 8'h01;
         end
         dwc_pkg::DWC_CRC_LOW, dwc_pkg::DWC_PAR_LOW:
         begin
            if (cnt_reg == 8'h00)
               state_next = dwc_pkg::DWC_IDLE;
            else
               cnt_next = cnt_reg - 8'h01;
         end
         default:
            state_next = dwc_pkg::DWC_IDLE;
      endcase
      oe_next = (state_next == dwc_pkg::DWC_CRC_LOW) || (state_next == dwc_pkg::DWC_PAR_LOW);
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg    <= dwc_pkg::DWC_IDLE;
         cnt_reg      <= 8'h00;
         status_reg   <= 1'b0;
         alert_oe_out <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         status_reg   <= status_next;
         alert_oe_out <= oe_next;
      end
   end

   assign alert_n_out                  = 1'b0;
   assign crc_error_status_out         = status_reg;
   assign error_log_register_three_out = {status_reg, 7'h00};

   // ----------------------------------------
   // Read encoder
   // ----------------------------------------
   logic [15:0] rd_dq_next;
   logic [1:0]  rd_flag_next;

   always_comb
   begin
      rd_dq_next   = read_data_in;
      rd_flag_next = 2'h3;
      for (int l = 0; l < 2; l++)
      begin
         if (rd_inv_en && !multipurpose_register_read_in &&
             zero_count(read_data_in[l*8 +: 8]) > `DWC_ZERO_LIMIT)
         begin
            rd_dq_next[l*8 +: 8] = ~read_data_in[l*8 +: 8];
            rd_flag_next[l]      = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dq_out                        <= 16'h0000;
         dq_oe_out                     <= 1'b0;
         lower_lane_invert_flag_n_out  <= 1'b1;
         upper_lane_invert_flag_n_out  <= 1'b1;
         lower_lane_invert_flag_oe_out <= 1'b0;
         upper_lane_invert_flag_oe_out <= 1'b0;
      end
      else
      begin
         dq_out                        <= rd_dq_next;
         dq_oe_out                     <= read_valid_in;
         lower_lane_invert_flag_n_out  <= rd_flag_next[0];
         upper_lane_invert_flag_n_out  <= rd_flag_next[1];
         lower_lane_invert_flag_oe_out <= read_valid_in && rd_inv_en;
         upper_lane_invert_flag_oe_out <= read_valid_in && rd_inv_en && data_width_in == dwc_pkg::DWC_X16;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [7:0] low_len_reg;

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         low_len_reg <= 8'h00;
      else if (alert_oe_out)
         low_len_reg <= low_len_reg + 8'h01;
      else
         low_len_reg <= 8'h00;
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence crc_report_s;
      mismatch_reg && state_reg == dwc_pkg::DWC_IDLE && !command_address_parity_err_in;
   endsequence

   status_set_a: assert property (mismatch_reg |=> crc_error_status_out) else $error("status not set");
   log_mirror_a: assert property (mismatch_reg |=> error_log_register_three_out[7]) else $error("log flag");
   status_hold_a: assert property (crc_error_status_out && !mode_register_set_command_in
      |=> crc_error_status_out) else $error("status lost");
   alert_start_a: assert property (crc_report_s |=> state_reg == dwc_pkg::DWC_WAIT) else $error("no start");
   alert_latency_a: assert property (crc_report_s |-> ##LAT_P1 alert_oe_out) else $error("latency");
   crc_pulse_a: assert property (state_reg == dwc_pkg::DWC_CRC_LOW |-> low_len_reg < 8'h0a)
      else $error("pulse too long");
   parity_pulse_a: assert property ($fell(alert_oe_out) && $past(state_reg) == dwc_pkg::DWC_PAR_LOW
      |-> $past(low_len_reg) >= 8'h2d) else $error("parity pulse short");
   narrow_read_a: assert property (read_valid_in && data_width_in == dwc_pkg::DWC_X4
      |=> dq_out == $past(read_data_in) && !lower_lane_invert_flag_oe_out) else $error("x4 inverted");
   mpr_plain_a: assert property (read_valid_in && multipurpose_register_read_in
      |=> dq_out == $past(read_data_in)) else $error("mpr inverted");
   read_invert_a: assert property (read_valid_in && rd_inv_en && !multipurpose_register_read_in
      && zero_count(read_data_in[7:0]) > 4'h4 |=> dq_out[7:0] == ~$past(read_data_in[7:0])
      && !lower_lane_invert_flag_n_out) else $error("read inversion");
   write_invert_a: assert property (push_next && wr_inv_en && !pin_s2_reg.flag_n[0]
      |=> push_word_reg.data[7:0] == ~$past(pin_s2_reg.dq[7:0])) else $error("write inversion");
   write_plain_a: assert property (push_next && pin_s2_reg.flag_n[0]
      |=> push_word_reg.data[7:0] == $past(pin_s2_reg.dq[7:0])) else $error("write altered");
endmodule : dwc_top

//--- dwc_ctrl_model.sv
// Behavioural memory controller side of the write link.
// Assumes the bench calls send_burst; the strobe stays still between frames.
`timescale 1ns/1ps
module dwc_ctrl_model (
   output logic        strobe_out,
   output logic        frame_out,
   output logic [15:0] dq_out,
   output logic        lower_flag_n_out,
   output logic        upper_flag_n_out
);
   initial
   begin
      strobe_out = 1'b0;
      frame_out = 1'b0;
      dq_out = 16'h0000;
      lower_flag_n_out = 1'b1;
      upper_flag_n_out = 1'b1;
   end

   // Sends n beats at a 160 ns strobe period, then drives the inverse of the last value.
   task automatic send_burst(input dwc_pkg::dwc_beat_t b [9], input int n);
      frame_out = 1'b1;
      #80;
      for (int i = 0; i < n; i++)
      begin
         {dq_out, upper_flag_n_out, lower_flag_n_out} = b[i];
         #80 strobe_out = 1'b1;
         #80 strobe_out = 1'b0;
      end
      #80 frame_out = 1'b0;
      {dq_out, upper_flag_n_out, lower_flag_n_out} = ~{dq_out, upper_flag_n_out, lower_flag_n_out};
      #160;
   endtask : send_burst
endmodule : dwc_ctrl_model

//--- dwc_top_tb.sv
// Self-checking bench of the checksum alert and bus inversion block.
// Assumes the controller model drives the write link pins.
`timescale 1ns/1ps
`include "dwc_defs.svh"
module dwc_top_tb;
   logic                mclk_in, rst_in, mode_register_set_command, crc_en, multipurpose_register, par, rd_v, stall;
   logic                ready = 1'b0;
   dwc_pkg::dwc_width_t width;
   logic [15:0]         mr5, mr1, rd_d, dq_o;
   logic [15:0]         lfsr = 16'h0026;
   wire logic           stb, frm, lfl, ufl, alert_line;
   wire logic [15:0]    ldq;
   logic                dq_oe, lfo, ufo, lfe, ufe, al_n, al_oe, b_rdy, s_v, stat;
   dwc_pkg::dwc_store_t s_w;
   logic [7:0]          log3;
   logic [17:0]         sq[$];
   logic [37:0]         rq[$];
   logic [37:0]         rn;
   int                  fails, samples_checked, low_cnt;
   logic [1:0]          rw [7] = '{2'b10, 2'b01, 2'b10, 2'b00, 2'b10, 2'b01, 2'b10};
   logic [15:0]         rm5 [7] = '{16'h1000, 16'h1400, 16'h1800, 16'h1000, 16'h1000, 16'h0000, 16'h0800};
   logic [6:0]          termination_strobe_function = 7'b0100000;
   logic [6:0]          mprs = 7'b0010000;
   assign alert_line = al_oe ? al_n : 1'b1;

   dwc_ctrl_model dwc_ctrl_model_inst (.strobe_out(stb), .frame_out(frm), .dq_out(ldq),
      .lower_flag_n_out(lfl), .upper_flag_n_out(ufl));
   dwc_top dwc_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .data_width_in(width), .mode_register_five_in(mr5),
      .mode_register_one_in(mr1), .mode_register_set_command_in(mode_register_set_command), .write_crc_enable_in(crc_en),
      .multipurpose_register_read_in(multipurpose_register), .command_address_parity_err_in(par), .link_strobe_in(stb),
      .write_frame_in(frm), .dq_in(ldq), .dq_out(dq_o), .dq_oe_out(dq_oe), .lower_lane_invert_flag_n_in(lfl),
      .lower_lane_invert_flag_n_out(lfo), .lower_lane_invert_flag_oe_out(lfe), .upper_lane_invert_flag_n_in(ufl),
      .upper_lane_invert_flag_n_out(ufo), .upper_lane_invert_flag_oe_out(ufe), .alert_n_out(al_n),
      .alert_oe_out(al_oe), .read_valid_in(rd_v), .read_data_in(rd_d), .beat_ready_out(b_rdy),
      .store_valid_out(s_v), .store_ready_in(ready), .store_word_out(s_w), .crc_error_status_out(stat),
      .error_log_register_three_out(log3));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [8:0] d);
      logic fb;
      for (int i = 8; i >= 0; i--)
      begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? `DWC_CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc_step

   task automatic chk_store(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t store got %h exp %h", $time, got, exp);
      end
   endtask : chk_store

   task automatic chk_read(input logic [17:0] got, input logic [17:0] exp, input logic [17:0] care);
      samples_checked++;
      if ((got & care) !== (exp & care))
      begin
         fails++;
         $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
      end
   endtask : chk_read

   task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #2;
   endtask : wait_cyc

   // Builds one random burst, notes the stored words and sends it.
   task automatic burst(input logic bad);
      dwc_pkg::dwc_beat_t b [9];
      logic [7:0]         cl, cu;
      logic [17:0]        e;
      cl = `DWC_CRC_INIT;
      cu = `DWC_CRC_INIT;
      for (int i = 0; i < 8; i++)
      begin
         lfsr = lfsr_next(lfsr);
         b[i].dq = lfsr;
         lfsr = lfsr_next(lfsr);
         b[i].flag_n = lfsr[1:0];
         cl = crc_step(cl, {b[i].dq[7:0], b[i].flag_n[0]});
         cu = crc_step(cu, {b[i].dq[15:8], b[i].flag_n[1]});
         for (int l = 0; l < 2; l++)
         begin
            e[16+l] = mr5[10] & ~b[i].flag_n[l];
            e[8*l+:8] = (mr5[11] & ~b[i].flag_n[l]) ? ~b[i].dq[8*l+:8] : b[i].dq[8*l+:8];
         end
         sq.push_back(e);
      end
      b[8].dq = {cu, cl ^ {7'h00, bad}};
      b[8].flag_n = 2'b11;
      dwc_ctrl_model_inst.send_burst(b, crc_en ? 9 : 8);
   endtask : burst

   // ----------------------------------------
   // Monitor and drivers
   // ----------------------------------------
   always @(negedge mclk_in)
   begin
      if (alert_line === 1'b0) low_cnt++;
      if (s_v === 1'b1 && ready === 1'b1)
         chk_store(s_w, sq.size() ? sq.pop_front() : ~s_w);
      if (dq_oe === 1'b1)
      begin
         rn = rq.size() ? rq.pop_front() : {2'b00, 18'h3ffff, ~{ufo, lfo, dq_o}};
         chk_read({ufo, lfo, dq_o}, rn[17:0], rn[35:18]);
         chk_val({16'h0000, ufe, lfe}, rn[37:36]);
      end
   end

   always @(posedge mclk_in)
   begin
      #2;
      lfsr = lfsr_next(lfsr);
      ready = ~stall & (lfsr[0] | lfsr[3]);
   end

   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   initial
   begin
      #1900000;
      fails++;
      report_and_stop();
   end

   initial
   begin
      logic [17:0] e;
      logic        en;
      logic        ie;
      rst_in = 1'b1; width = dwc_pkg::DWC_X16; mr5 = 16'h0800; mr1 = 16'h0000; mode_register_set_command = 1'b0;
      crc_en = 1'b0; multipurpose_register = 1'b0; par = 1'b0; rd_v = 1'b0; rd_d = 16'h0000; stall = 1'b1;
      repeat (12) @(posedge mclk_in);
      #2 rst_in = 1'b0;
      chk_val({16'h0000, b_rdy, stat}, 18'h00002);
      repeat (4) burst(1'b0);
      wait_cyc(20);
      chk_val(b_rdy, 1'b0);
      stall = 1'b0;
      wait_cyc(200);
      mr5 = 16'h0400;
      burst(1'b0);
      wait_cyc(100);
      $display("write and fifo test done");
      mr5 = 16'h0800;
      crc_en = 1'b1;
      low_cnt = 0;
      burst(1'b0);
      wait_cyc(100);
      chk_val({low_cnt[16:0], stat}, 18'h00000);
      burst(1'b1);
      wait_cyc(100);
      chk_val(low_cnt, `DWC_CRC_PULSE_CLKS);
      chk_val({stat, log3}, 9'h180);
      burst(1'b0);
      mr5 = 16'h0808;
      mode_register_set_command = 1'b1;
      wait_cyc(1);
      mode_register_set_command = 1'b0;
      wait_cyc(2);
      chk_val({stat, log3}, 9'h180);
      mr5 = 16'h0800;
      mode_register_set_command = 1'b1;
      wait_cyc(1);
      mode_register_set_command = 1'b0;
      wait_cyc(2);
      chk_val({stat, log3}, 9'h000);
      low_cnt = 0;
      par = 1'b1;
      wait_cyc(1);
      par = 1'b0;
      wait_cyc(80);
      chk_val(low_cnt, `DWC_PARITY_PULSE_CLKS);
      $display("alert test done");
      for (int k = 0; k < 7; k++)
      begin
         width = dwc_pkg::dwc_width_t'(rw[k]);
         mr5 = rm5[k];
         mr1 = {4'h0, termination_strobe_function[k], 11'h000};
         multipurpose_register = mprs[k];
         ie = rm5[k][12] & ~termination_strobe_function[k] & (rw[k] != 2'b00);
         en = ie & ~mprs[k];
         for (int i = 0; i < 8; i++)
         begin
            lfsr = lfsr_next(lfsr);
            rd_d = (i == 0) ? 16'h070f : lfsr;
            rd_v = 1'b1;
            for (int l = 0; l < 2; l++)
            begin
               e[16+l] = ~(en & ($countones(rd_d[8*l+:8]) < 4));
               e[8*l+:8] = e[16+l] ? rd_d[8*l+:8] : ~rd_d[8*l+:8];
            end
            rq.push_back({ie & (rw[k] == 2'b10), ie, (rw[k] == 2'b01) ? 18'h100ff : 18'h3ffff, e});
            wait_cyc(1);
         end
         rd_v = 1'b0;
         wait_cyc(3);
      end
      $display("read test done");
      chk_val(sq.size() + rq.size(), 18'h00000);
      report_and_stop();
   end
endmodule : dwc_top_tb
